// ### pkg/sap_params.svh
// Offsets, field positions, reset values and timing counts of the audio port.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef SAP_PARAMS_SVH
`define SAP_PARAMS_SVH

// =====================================================================
// Register indices and byte addresses
// =====================================================================
`define SAP_IDX_CFG 16'hfe60
`define SAP_IDX_LEFT_LO 16'hfe61
`define SAP_IDX_LEFT_HI 16'hfe62
`define SAP_IDX_RIGHT_LO 16'hfe63
`define SAP_IDX_RIGHT_HI 16'hfe64
`define SAP_ADDR_CFG (`SAP_IDX_CFG * 4)
`define SAP_ADDR_LEFT_LO (`SAP_IDX_LEFT_LO * 4)
`define SAP_ADDR_LEFT_HI (`SAP_IDX_LEFT_HI * 4)
`define SAP_ADDR_RIGHT_LO (`SAP_IDX_RIGHT_LO * 4)
`define SAP_ADDR_RIGHT_HI (`SAP_IDX_RIGHT_HI * 4)

// =====================================================================
// Configuration and status fields
// =====================================================================
`define SAP_CFG_WIDTH 14
`define SAP_CFG_RESET 14'h0001
`define SAP_BIT_MASTER 0
`define SAP_BIT_MCK_EN 1
`define SAP_BIT_ENABLE 2
`define SAP_BIT_RATE_LO 3
`define SAP_BIT_RATE_HI 4
`define SAP_BIT_SOURCE 5
`define SAP_BIT_TX_UR 6
`define SAP_BIT_RX_OR 9
`define SAP_BIT_IRQ_EN 12
`define SAP_BIT_WIDE 13

// =====================================================================
// Timing
// =====================================================================
`define SAP_CLK_HZ 20000000
`define SAP_BCK_HZ_BASE 1536000
`define SAP_BCK_HZ_DOUBLE 3072000
`define SAP_BCK_HZ_QUAD 6144000
`define SAP_HALF_BASE (`SAP_CLK_HZ / (2 * `SAP_BCK_HZ_BASE))
`define SAP_HALF_DOUBLE (`SAP_CLK_HZ / (2 * `SAP_BCK_HZ_DOUBLE))
`define SAP_HALF_QUAD (`SAP_CLK_HZ / (2 * `SAP_BCK_HZ_QUAD))
`define SAP_FIFO_DEPTH 8
`define SAP_FIFO_WIDTH 32

`endif

// ### pkg/sap_pkg.sv
// Types shared by the stereo audio port design.
// Assumes the parameter header is on the include path.
`include "sap_params.svh"

package sap_pkg;

   // =================================================================
   // Configuration and status register layout
   // =================================================================
   typedef struct packed {
      logic wide;
      logic irq_en;
      logic rx_rf;
      logic rx_lf;
      logic rx_or;
      logic tx_rf;
      logic tx_lf;
      logic tx_ur;
      logic src;
      logic [1:0] rate;
      logic en;
      logic mck_en;
      logic master;
   } sap_cfg_t;

   // Framing state of the serial link.
   typedef enum logic [1:0] {
      SAP_IDLE,
      SAP_HUNT,
      SAP_RUN
   } sap_link_t;

endpackage : sap_pkg

// ### src/sap_port.sv
// Stereo serial audio port with APB registers and a sample FIFO.
// Assumes clk_sys at 20 MHz, the link pins asynchronous to it, and a
// rate converter stream that honours valid and ready.
//
// Design decision made here: register access over APB.

// =====================================================================
// Sample FIFO
// =====================================================================
module sap_fifo #(
   parameter int WIDTH = `SAP_FIFO_WIDTH,
   parameter int DEPTH = `SAP_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   // Handshakes on both sides.
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   // Occupancy after this cycle.
   always_comb begin
      next_count = count;
      if (push & ~pop) begin
         next_count = count + 1'b1;
      end else if (pop & ~push) begin
         next_count = count - 1'b1;
      end
   end

   // Pointers, count and registered full and empty.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= next_count;
         in_ready <= (next_count != (AW+1)'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end

   // Storage array.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : sap_fifo

// =====================================================================
// Audio port top
// =====================================================================
module sap_port
   import sap_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic crystal_clock,
   output logic crystal_clock_out,
   input wire logic bck_in,
   output logic bck_out,
   output logic bck_oe,
   input wire logic frm_in,
   output logic frm_out,
   output logic frm_oe,
   output logic dout,
   input wire logic din,
   input wire logic [31:0] filt_data,
   input wire logic filt_valid,
   output logic filt_ready,
   output logic irq
);
   sap_cfg_t cfg;
   sap_link_t link;
   logic [15:0] tx_left_lo, tx_left_hi, tx_right_lo, tx_right_hi;
   logic [31:0] rx_left, rx_right, rx_sh, tx_sh;
   logic bck_s1, bck_s2, bck_s3, frm_s1, frm_s2, frm_prev, din_s1, din_s2;
   logic [3:0] div_cnt;
   logic [3:0] half;
   logic [5:0] pos, next_pos, last, wm1;
   logic rx_armed, mck_gate, is_master, run;
   logic rise, fall, div_hit, copy_l, copy_r, store_l, store_r;
   logic access, wr, rd, setup, sel_cfg, sel_llo, sel_lhi, sel_rlo, sel_rhi;
   logic [31:0] fifo_data, tx_word, word_l, word_r, rx_word;
   logic fifo_valid, fifo_pop;

   // =================================================================
   // APB decode
   // =================================================================
   // Access phase completes in its first cycle, with no wait state.
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;
   // Data registers are reached by both directions.
   // shared data registers
   assign sel_cfg = (paddr == 32'(`SAP_ADDR_CFG));
   assign sel_llo = (paddr == 32'(`SAP_ADDR_LEFT_LO));
   assign sel_lhi = (paddr == 32'(`SAP_ADDR_LEFT_HI));
   assign sel_rlo = (paddr == 32'(`SAP_ADDR_RIGHT_LO));
   assign sel_rhi = (paddr == 32'(`SAP_ADDR_RIGHT_HI));

   // Read data, ready and error are captured in the setup cycle.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (setup) begin
            if (sel_cfg) begin
               prdata <= {18'h0, cfg};
            end else if (sel_llo) begin
               prdata <= {16'h0, rx_left[15:0]};
            end else if (sel_lhi) begin
               prdata <= {16'h0, rx_left[31:16]};
            end else if (sel_rlo) begin
               prdata <= {16'h0, rx_right[15:0]};
            end else if (sel_rhi) begin
               prdata <= {16'h0, rx_right[31:16]};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // Transmit word halves, written at any time.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_left_lo <= 16'h0;
         tx_left_hi <= 16'h0;
         tx_right_lo <= 16'h0;
         tx_right_hi <= 16'h0;
      end else if (wr) begin
         if (sel_llo) begin
            tx_left_lo <= pwdata[15:0];
         end
         if (sel_lhi) begin
            tx_left_hi <= pwdata[15:0];
         end
         if (sel_rlo) begin
            tx_right_lo <= pwdata[15:0];
         end
         if (sel_rhi) begin
            tx_right_hi <= pwdata[15:0];
         end
      end
   end

   // =================================================================
   // Configuration and status
   // =================================================================
   // Hardware sets come after software clears so that a set wins.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfg <= sap_cfg_t'(`SAP_CFG_RESET);
      end else begin
         if (wr & sel_cfg) begin
            if (!cfg.en) begin
               cfg.wide <= pwdata[`SAP_BIT_WIDE];
               cfg.irq_en <= pwdata[`SAP_BIT_IRQ_EN];
               cfg.src <= pwdata[`SAP_BIT_SOURCE];
               cfg.rate <= pwdata[`SAP_BIT_RATE_HI:`SAP_BIT_RATE_LO];
               cfg.mck_en <= pwdata[`SAP_BIT_MCK_EN];
               cfg.master <= pwdata[`SAP_BIT_MASTER];
            end
            cfg.en <= pwdata[`SAP_BIT_ENABLE];
            if (!pwdata[`SAP_BIT_RX_OR]) begin
               cfg.rx_or <= 1'b0;
            end
            if (!pwdata[`SAP_BIT_TX_UR]) begin
               cfg.tx_ur <= 1'b0;
            end
         end
         if (copy_l & cfg.src) begin
            cfg.tx_lf <= 1'b0;
         end
         if (copy_r & cfg.src) begin
            cfg.tx_rf <= 1'b0;
         end
         if (wr & sel_lhi) begin
            cfg.tx_lf <= 1'b1;
         end
         if (wr & sel_rhi) begin
            cfg.tx_rf <= 1'b1;
         end
         if (cfg.src & ((copy_l & ~cfg.tx_lf) | (copy_r & ~cfg.tx_rf))) begin
            cfg.tx_ur <= 1'b1;
         end
         if (rd & sel_lhi) begin
            cfg.rx_lf <= 1'b0;
         end
         if (rd & sel_rhi) begin
            cfg.rx_rf <= 1'b0;
         end
         if (store_l) begin
            cfg.rx_lf <= 1'b1;
         end
         if (store_r) begin
            cfg.rx_rf <= 1'b1;
         end
         if (store_l & (cfg.rx_lf | cfg.rx_rf)) begin
            cfg.rx_or <= 1'b1;
         end
      end
   end

   // Interrupt request as a registered level.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= cfg.irq_en & cfg.en & (cfg.rx_lf | cfg.rx_rf |
                (cfg.src & ~cfg.tx_lf & ~cfg.tx_rf));
      end
   end

   // =================================================================
   // Crystal clock pad
   // =================================================================
   // The gate is a flop so the pad enable is steady between writes.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mck_gate <= 1'b0;
      end else begin
         mck_gate <= cfg.mck_en;
      end
   end
   assign crystal_clock_out = crystal_clock & mck_gate;

   // =================================================================
   // Pin synchronisers
   // =================================================================
   // Two flops per pin, a third only for bit clock edge detection.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bck_s1 <= 1'b0;
         bck_s2 <= 1'b0;
         bck_s3 <= 1'b0;
         frm_s1 <= 1'b0;
         frm_s2 <= 1'b0;
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end else begin
         bck_s1 <= bck_in;
         bck_s2 <= bck_s1;
         bck_s3 <= bck_s2;
         frm_s1 <= frm_in;
         frm_s2 <= frm_s1;
         din_s1 <= din;
         din_s2 <= din_s1;
      end
   end

   // =================================================================
   // Bit clock generation and edge events
   // =================================================================
   // Filter source forces master operation.
   // role select
   assign is_master = cfg.master | ~cfg.src;
   always_comb begin
      case (cfg.rate)
         2'b01: half = 4'(`SAP_HALF_DOUBLE);
         2'b10: half = 4'(`SAP_HALF_QUAD);
         default: half = 4'(`SAP_HALF_BASE);
      endcase
   end
   assign div_hit = (div_cnt == half - 4'h1);
   assign rise = cfg.en & (is_master ? (div_hit & ~bck_out)
                                     : (bck_s2 & ~bck_s3));
   assign fall = cfg.en & (is_master ? (div_hit & bck_out)
                                     : (~bck_s2 & bck_s3));

   // Divider toggles the bit clock and drives the pins as master.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div_cnt <= 4'h0;
         bck_out <= 1'b0;
         bck_oe <= 1'b0;
         frm_oe <= 1'b0;
      end else begin
         bck_oe <= cfg.en & is_master;
         frm_oe <= cfg.en & is_master;
         if (!cfg.en || !is_master) begin
            div_cnt <= 4'h0;
            bck_out <= 1'b0;
         end else if (div_hit) begin
            div_cnt <= 4'h0;
            bck_out <= ~bck_out;
         end else begin
            div_cnt <= div_cnt + 4'h1;
         end
      end
   end

   // =================================================================
   // Frame position
   // =================================================================
   // word size
   assign last = cfg.wide ? 6'd63 : 6'd31;
   assign wm1 = cfg.wide ? 6'd31 : 6'd15;
   assign next_pos = (pos == last) ? 6'd0 : pos + 6'd1;
   assign run = (link == SAP_RUN);

   // Position advances on falling edges; followers resync on frame sync.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         link <= SAP_IDLE;
         pos <= 6'd0;
         frm_out <= 1'b0;
         frm_prev <= 1'b0;
      end else begin
         case (link)
            SAP_IDLE: begin
               pos <= last;
               frm_out <= 1'b0;
               if (cfg.en) begin
                  link <= is_master ? SAP_RUN : SAP_HUNT;
               end
            end
            default: begin
               if (fall & run) begin
                  pos <= next_pos;
                  // sync leads the word by one bit
                  frm_out <= (next_pos >= wm1) && (next_pos != last);
               end
               if (rise & ~is_master) begin
                  frm_prev <= frm_s2;
                  if (frm_prev & ~frm_s2) begin
                     link <= SAP_RUN;
                     pos <= last;
                  end
               end
               if (!cfg.en) begin
                  link <= SAP_IDLE;
               end
            end
         endcase
      end
   end

   // =================================================================
   // Transmitter
   // =================================================================
   // left copied at frame start
   assign copy_l = fall & run & (next_pos == 6'd0);
   assign copy_r = fall & run & (next_pos == wm1 + 6'd1);
   assign word_l = cfg.wide ? {tx_left_hi, tx_left_lo} : {tx_left_hi, 16'h0};
   assign word_r = cfg.wide ? {tx_right_hi, tx_right_lo}
                            : {tx_right_hi, 16'h0};
   always_comb begin
      tx_word = 32'h0;
      if (cfg.src) begin
         tx_word = copy_l ? word_l : word_r;
      end else if (fifo_valid) begin
         tx_word = fifo_data;
      end
   end
   assign fifo_pop = ~cfg.src & (copy_l | copy_r);

   // Shifter loads at each word start and shifts on falling edges.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_sh <= 32'h0;
         dout <= 1'b0;
      end else if (!cfg.en) begin
         tx_sh <= 32'h0;
         dout <= 1'b0;
      end else if (copy_l | copy_r) begin
         dout <= tx_word[31];
         tx_sh <= {tx_word[30:0], 1'b0};
      end else if (fall & run) begin
         dout <= tx_sh[31];
         tx_sh <= {tx_sh[30:0], 1'b0};
      end
   end

   sap_fifo #(
      .WIDTH(`SAP_FIFO_WIDTH),
      .DEPTH(`SAP_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .in_data(filt_data),
      .in_valid(filt_valid),
      .in_ready(filt_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // =================================================================
   // Receiver
   // =================================================================
   assign store_l = rise & run & (pos == wm1);
   assign store_r = rise & run & rx_armed & (pos == last);
   assign rx_word = cfg.wide ? {rx_sh[30:0], din_s2}
                             : {rx_sh[14:0], din_s2, 16'h0};

   // Data sampled on rising edges, words stored at their last bit.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_sh <= 32'h0;
         rx_left <= 32'h0;
         rx_right <= 32'h0;
         rx_armed <= 1'b0;
      end else if (!cfg.en) begin
         rx_armed <= 1'b0;
      end else if (rise & run) begin
         rx_sh <= {rx_sh[30:0], din_s2};
         if (store_l) begin
            rx_left <= rx_word;
            rx_armed <= 1'b1;
         end
         if (store_r) begin
            rx_right <= rx_word;
         end
      end
   end
endmodule : sap_port

// ### dv/sap_port_properties.sv
// Concurrent checks on the audio port pins and APB answer timing.
// Assumes the parameter header is on the include path; bound to sap_port.
`include "sap_params.svh"

// =====================================================================
// Checker
// =====================================================================
module sap_port_properties (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic crystal_clock,
   input wire logic crystal_clock_out,
   input wire logic bck_out,
   input wire logic bck_oe,
   input wire logic frm_out,
   input wire logic frm_oe,
   input wire logic dout
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Decodes the five register words.
   wire mapped = paddr inside {`SAP_ADDR_CFG, `SAP_ADDR_LEFT_LO,
      `SAP_ADDR_LEFT_HI, `SAP_ADDR_RIGHT_LO, `SAP_ADDR_RIGHT_HI};
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   property p_ready_next;
      s_setup |=> pready;
   endproperty
   property p_ready_once;
      pready |=> !pready;
   endproperty
   property p_err_unmapped;
      s_access and !mapped |-> pslverr && prdata == 32'h0;
   endproperty
   property p_ok_mapped;
      pready && mapped |-> !pslverr;
   endproperty
   property p_xtal_gate;
      crystal_clock_out |-> crystal_clock;
   endproperty
   property p_oe_pair;
      bck_oe == frm_oe;
   endproperty
   property p_dout_fall;
      $stable(bck_oe) && bck_oe && $changed(dout) |-> !bck_out;
   endproperty
   property p_frm_fall;
      $stable(frm_oe) && frm_oe && $changed(frm_out) |-> !bck_out;
   endproperty
   a_ready_next: assert property (p_ready_next) else $error("no pready");
   a_ready_once: assert property (p_ready_once) else $error("long pready");
   a_err_unmapped: assert property (p_err_unmapped) else $error("no err");
   a_ok_mapped: assert property (p_ok_mapped) else $error("bad err");
   a_xtal_gate: assert property (p_xtal_gate) else $error("xtal out");
   a_oe_pair: assert property (p_oe_pair) else $error("oe split");
   a_dout_fall: assert property (p_dout_fall) else $error("dout edge");
   a_frm_fall: assert property (p_frm_fall) else $error("frm edge");
endmodule : sap_port_properties

bind sap_port sap_port_properties u_props (.clk_sys(clk_sys),
   .resetn(resetn), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .crystal_clock(crystal_clock), .crystal_clock_out(crystal_clock_out),
   .bck_out(bck_out), .bck_oe(bck_oe), .frm_out(frm_out),
   .frm_oe(frm_oe), .dout(dout));

// ### dv/sap_codec_model.sv
// Behavioural external codec on the serial audio link, 16-bit words.
// Assumes the bench resolves bck and frm from both drivers.

// =====================================================================
// Codec model
// =====================================================================
module sap_codec_model (
   input wire logic drive,
   input wire logic [15:0] tx_l,
   input wire logic [15:0] tx_r,
   input wire logic bck_w,
   input wire logic frm_w,
   input wire logic dout,
   output logic bck,
   output logic frm,
   output logic din,
   output logic [31:0] rx_l,
   output logic [31:0] rx_r,
   output int n_r
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] sh = 32'h0;
   logic pf = 1'b0;
   int cnt = 0;
   assign n_r = cnt;
   // clock, frame, MSB first
   // Clock stands high between frames; din toggles so no stale level.
   initial begin
      bck = 1'b1;
      frm = 1'b1;
      din = 1'b0;
      forever begin
         if (!drive) begin
            #200 din = ~din;
         end else begin
            for (int i = 0; i < 32; i++) begin
               bck = 1'b0; // launch on fall
               frm = (i >= 15 && i != 31);
               din = (i < 16) ? tx_l[15-i] : tx_r[31-i];
               #200 bck = 1'b1;
               #200;
            end
         end
      end
   end
   // sample on rise
   // A frame sync edge closes the word whose LSB is on the line now.
   always @(posedge bck_w) begin
      sh <= {sh[30:0], dout};
      if (frm_w && !pf) rx_l <= {sh[30:0], dout};
      if (!frm_w && pf) begin
         rx_r <= {sh[30:0], dout};
         cnt <= cnt + 1;
      end
      pf <= frm_w;
   end
endmodule : sap_codec_model

// ### dv/sap_port_tb.sv
// Self-checking bench for the stereo audio port over APB and the link.
// Assumes the parameter header on the include path and the codec model.
`include "sap_params.svh"

// =====================================================================
// Bench top
// =====================================================================
module sap_port_tb;
   import sap_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, filt_data = 0, rdat;
   logic [31:0] rx_l, rx_r;
   logic pready, pslverr, xo, bck_out, bck_oe, frm_out, frm_oe, dout;
   logic xtal = 0, filt_valid = 0, filt_ready, irq, slv, drive = 0;
   logic m_bck, m_frm, m_din;
   logic [15:0] m_l = 16'ha5c3, m_r = 16'h3c5a;
   int errors = 0, checks_done = 0, n_r;
   // Resolved link pins.
   wire bck_w = bck_oe ? bck_out : m_bck;
   wire frm_w = frm_oe ? frm_out : m_frm;
   sap_port dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .crystal_clock(xtal), .crystal_clock_out(xo), .bck_in(bck_w),
      .bck_out(bck_out), .bck_oe(bck_oe), .frm_in(frm_w),
      .frm_out(frm_out), .frm_oe(frm_oe), .dout(dout), .din(m_din),
      .filt_data(filt_data), .filt_valid(filt_valid),
      .filt_ready(filt_ready), .irq(irq));
   sap_codec_model codec (.drive(drive), .tx_l(m_l), .tx_r(m_r),
      .bck_w(bck_w), .frm_w(frm_w), .dout(dout), .bck(m_bck),
      .frm(m_frm), .din(m_din), .rx_l(rx_l), .rx_r(rx_r), .n_r(n_r));
   // Clocks: system at 50 ns, crystal unrelated in phase.
   initial forever #25 clk_sys = ~clk_sys;
   initial forever #41 xtal = ~xtal;
   task automatic final_report;
      if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One APB transfer; waits for pready under a bound.
   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys) penable <= 1;
      n = 0;
      do begin @(posedge clk_sys); n++; end
      while (pready !== 1'b1 && n < 20);
      chk("pready", 1, pready);
      rdat = prdata;
      slv = pslverr;
      psel <= 0; penable <= 0;
      @(posedge clk_sys);
   endtask : apb
   task automatic wait_frames(input int k);
      int c, n;
      c = n_r;
      n = 0;
      while (n_r < c + k && n < 9000) begin @(posedge clk_sys); n++; end
      chk("frames", 1, n < 9000);
   endtask : wait_frames
   task automatic t_reset;
      apb(0, `SAP_ADDR_CFG, 0); chk("cfg", 32'h1, rdat);
      apb(0, `SAP_ADDR_CFG + 20, 0); chk("unmapped", 1, slv);
      apb(1, `SAP_ADDR_CFG, 32'h3);
      repeat (3) @(posedge xtal) #1 chk("xtal", 1, xo);
      apb(1, `SAP_ADDR_CFG, 32'h1);
      @(posedge xtal) #1 chk("xtal off", 0, xo);
   endtask : t_reset
   task automatic t_master;
      int h, k;
      int exp_h[4] = '{6, 3, 1, 6};
      apb(1, `SAP_ADDR_LEFT_HI, 32'h1234);
      apb(1, `SAP_ADDR_RIGHT_HI, 32'hfedc);
      apb(0, `SAP_ADDR_CFG, 0); chk("txfull", 3, rdat[8:7]);
      apb(1, `SAP_ADDR_CFG, 32'h25);
      // Two frame ends, since the idle link level may fake the first one.
      wait_frames(2);
      chk("left word", 32'h1234, rx_l[15:0]);
      chk("right word", 32'hfedc, rx_r[15:0]);
      wait_frames(1);
      apb(0, `SAP_ADDR_CFG, 0); chk("txfull clr", 0, rdat[8:7]);
      chk("underrun", 1, rdat[6]);
      chk("irq off", 0, irq);
      apb(1, `SAP_ADDR_CFG, 32'h102d);
      apb(0, `SAP_ADDR_CFG, 0); chk("locked", 32'h25, rdat & 32'h303f);
      for (int c = 0; c < 4; c++) begin
         apb(1, `SAP_ADDR_CFG, 32'h21 | (c << 3));
         apb(1, `SAP_ADDR_CFG, 32'h25 | (c << 3));
         repeat (2) begin
            k = 0;
            h = bck_out;
            while (bck_out === h && k < 60) begin @(posedge clk_sys); k++; end
         end
         h = bck_out;
         k = 0;
         while (bck_out === h && k < 60) begin @(posedge clk_sys); k++; end
         chk("half period", exp_h[c], k);
      end
      apb(1, `SAP_ADDR_CFG, 32'h21);
   endtask : t_master
   task automatic t_follower;
      apb(1, `SAP_ADDR_CFG, 32'h1024);
      chk("follower oe", 0, bck_oe);
      drive = 1;
      wait_frames(4);
      drive = 0;
      apb(0, `SAP_ADDR_CFG, 0); chk("rx flags", 7, rdat[11:9]);
      chk("irq on", 1, irq);
      apb(0, `SAP_ADDR_LEFT_HI, 0); chk("rx left", 32'ha5c3, rdat);
      apb(0, `SAP_ADDR_RIGHT_HI, 0); chk("rx right", 32'h3c5a, rdat);
      apb(0, `SAP_ADDR_LEFT_LO, 0); chk("rx lo", 0, rdat);
      apb(1, `SAP_ADDR_CFG, 32'h1024);
      apb(0, `SAP_ADDR_CFG, 0); chk("rx clr", 0, rdat[11:9]);
      apb(1, `SAP_ADDR_CFG, 32'h1020);
   endtask : t_follower
   task automatic t_filter;
      int n, k;
      apb(1, `SAP_ADDR_CFG, 32'h0);
      n = 0;
      filt_valid <= 1;
      for (k = 0; k < 12; k++) begin
         filt_data <= (32'h100 + n) << 16;
         @(posedge clk_sys);
         if (filt_ready === 1'b1) n++;
      end
      filt_valid <= 0;
      chk("fifo depth", 8, n);
      apb(1, `SAP_ADDR_CFG, 32'h4);
      @(posedge clk_sys);
      chk("filter master", 1, bck_oe);
      wait_frames(1);
      chk("filter left", 32'h100, rx_l[15:0]);
      chk("filter right", 32'h101, rx_r[15:0]);
      k = 0;
      while (filt_ready !== 1'b1 && k < 4000) begin
         @(posedge clk_sys);
         k++;
      end
      chk("fifo drain", 1, filt_ready);
      apb(1, `SAP_ADDR_CFG, 32'h0);
   endtask : t_filter
   // Watchdog against a hung handshake.
   initial begin
      #3000000;
      errors++;
      final_report();
   end
   // Main sequence.
   initial begin
      repeat (5) @(posedge clk_sys);
      resetn <= 1;
      @(posedge clk_sys);
      t_reset();
      t_master();
      t_follower();
      t_filter();
      final_report();
   end
endmodule : sap_port_tb
